// >>> lid_bridge_decode.sv
// Legacy I/O range gating and IRQ pass decode with APB register file
//
// Overview of operation
// - Forward I/O cycles either direction only when port falls in an enabled block.
// - Low register bit 0 gates port 0x080; it resets to enabled.
// - Low register bit 1 gates ports 0x100 to 0x1CF.
// - Low register bit 2 gates ports 0x200 to 0x2E7.
// - Low register bit 3 gates ports 0x2E8 to 0x2EF.
// - Low register bit 4 gates ports 0x2F0 to 0x2F7.
// - Low register bit 5 gates ports 0x2F8 to 0x2FF.
// - Low register bit 6 gates ports 0x300 to 0x377.
// - Low register bit 7 gates ports 0x378 to 0x3E7.
// - High register bit 0 gates ports 0x3E8 to 0x3EF.
// - High register bit 1 gates ports 0x3F0 to 0x3F7.
// - High register bit 2 gates ports 0x3F8 to 0x3FF.
// - High register bit 3 gates ports 0x400 to 0xAFF.
// - High register bits 7 to 4 never affect forwarding.
// - All gate registers read and write at runtime, effective next cycle.
// - Each legacy IRQ has a pass bit; only passed requests reach serial IRQ.
// - IRQ pass bits 7..0 carry lines 11, 10, 9, 7, 6, 5, 4, 3.
`timescale 1ns/10ps

module lid_bridge_decode
(
    // Clock and reset
    input  wire logic                        pclk,
    input  wire logic                        presetn,
    // APB slave
    input  wire logic                        psel,
    input  wire logic                        penable,
    input  wire logic                        pwrite,
    input  wire logic [lid_pkg::ADDR_W-1:0]  paddr,
    input  wire logic [lid_pkg::DATA_W-1:0]  pwdata,
    input  wire logic [3:0]                  pstrb,
    output logic      [lid_pkg::DATA_W-1:0]  prdata,
    output logic                             pready,
    output logic                             pslverr,
    // I/O cycles from the LPC side
    input  wire lid_pkg::lid_io_cyc_t        lpc_cyc,
    output logic                             to_pc104_claim,
    // I/O cycles from the expansion bus side
    input  wire lid_pkg::lid_io_cyc_t        pc104_cyc,
    output logic                             to_lpc_claim,
    // Legacy interrupt requests
    input  wire logic [lid_pkg::NUM_IRQ-1:0] pc104_irq,
    output logic      [lid_pkg::NUM_IRQ-1:0] serirq_req
);

    // Registers
    logic [7:0]                  io_range_gates_low_reg;
    logic [7:0]                  io_range_gates_high_reg;
    logic [7:0]                  legacy_irq_pass_gates_reg;
    logic                        pready_reg;
    logic                        pslverr_reg;
    logic [lid_pkg::DATA_W-1:0]  prdata_reg;
    logic                        to_pc104_claim_reg;
    logic                        to_lpc_claim_reg;
    logic [lid_pkg::NUM_IRQ-1:0] serirq_req_reg;

    // APB decode
    wire                         acc_first;
    wire                         acc_done;
    wire                         sel_low;
    wire                         sel_high;
    wire                         sel_irq;
    wire                         mapped;
    wire                         wr_lane0;
    wire                         wr_low;
    wire                         wr_high;
    wire                         wr_irq;
    wire [7:0]                   rd_byte;
    wire [lid_pkg::DATA_W-1:0]   prdata_next;

    // Block gates
    wire                         port80_gate;
    wire                         range_100_gate;
    wire                         range_200_gate;
    wire                         range_2e8_gate;
    wire                         range_2f0_gate;
    wire                         range_2f8_gate;
    wire                         range_300_gate;
    wire                         range_378_gate;
    wire                         range_3e8_gate;
    wire                         range_3f0_gate;
    wire                         range_3f8_gate;
    wire                         range_400_gate;
    wire [lid_pkg::NUM_BLOCKS-1:0] gate_vec;
    wire [lid_pkg::NUM_BLOCKS-1:0] lpc_in_blk;
    wire [lid_pkg::NUM_BLOCKS-1:0] pc104_in_blk;
    wire                         lpc_hit;
    wire                         pc104_hit;

    // IRQ pass bits
    wire                         line3_pass;
    wire                         line4_pass;
    wire                         line5_pass;
    wire                         line6_pass;
    wire                         line7_pass;
    wire                         line9_pass;
    wire                         line10_pass;
    wire                         line11_pass;
    wire [lid_pkg::NUM_IRQ-1:0]  pass_vec;
    wire [lid_pkg::NUM_IRQ-1:0]  serirq_req_next;

    // One wait state: first access cycle, then pready high
    assign acc_first = psel & penable & ~pready_reg;
    assign acc_done  = psel & penable & pready_reg;

    assign sel_low  = (paddr == lid_pkg::ADDR_GATES_LOW);
    assign sel_high = (paddr == lid_pkg::ADDR_GATES_HIGH);
    assign sel_irq  = (paddr == lid_pkg::ADDR_IRQ_GATES);
    assign mapped   = sel_low | sel_high | sel_irq;

    // Only byte lane 0 carries register data
    assign wr_lane0 = acc_done & pwrite & pstrb[0];
    assign wr_low   = wr_lane0 & sel_low;
    assign wr_high  = wr_lane0 & sel_high;
    assign wr_irq   = wr_lane0 & sel_irq;

    assign rd_byte = sel_low  ? io_range_gates_low_reg :
                     sel_high ? io_range_gates_high_reg :
                     sel_irq  ? legacy_irq_pass_gates_reg : 8'h00;
    assign prdata_next = (acc_first & ~pwrite) ? {24'h000000, rd_byte} : 32'h00000000;

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            pready_reg  <= 1'b0;
            pslverr_reg <= 1'b0;
            prdata_reg  <= 32'h00000000;
        end
        else
        begin
            pready_reg  <= acc_first;
            pslverr_reg <= acc_first & ~mapped;
            prdata_reg  <= prdata_next;
        end
    end

    // Answer shape: one cycle, error and data only with it
    a_ready_single : assert property (@(posedge pclk) disable iff (!presetn)
        pready |=> !pready)
        else $error("pready held longer than one cycle");

    a_err_with_ready : assert property (@(posedge pclk) disable iff (!presetn)
        pslverr |-> pready)
        else $error("pslverr raised without pready");

    a_idle_data : assert property (@(posedge pclk) disable iff (!presetn)
        !pready |-> prdata == 32'h00000000)
        else $error("read data driven outside an answer");

    a_upper_zero : assert property (@(posedge pclk) disable iff (!presetn)
        prdata[31:8] == 24'h000000)
        else $error("read data upper bits not zero");

    // Gate registers
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            io_range_gates_low_reg <= lid_pkg::RST_GATES_LOW;
        else if (wr_low)
            io_range_gates_low_reg <= pwdata[7:0];
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            io_range_gates_high_reg <= lid_pkg::RST_GATES_HIGH;
        else if (wr_high)
            io_range_gates_high_reg <= pwdata[7:0];
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            legacy_irq_pass_gates_reg <= lid_pkg::RST_IRQ_GATES;
        else if (wr_irq)
            legacy_irq_pass_gates_reg <= pwdata[7:0];
    end

    // Writes land only on a mapped address with lane 0 strobed
    a_low_write : assert property (@(posedge pclk) disable iff (!presetn)
        (psel && penable && pready && pwrite && pstrb[0] && paddr == lid_pkg::ADDR_GATES_LOW)
        |=> io_range_gates_low_reg == $past(pwdata[7:0]))
        else $error("low gate register write did not take effect");

    a_irq_write : assert property (@(posedge pclk) disable iff (!presetn)
        (psel && penable && pready && pwrite && pstrb[0] && paddr == lid_pkg::ADDR_IRQ_GATES)
        |=> legacy_irq_pass_gates_reg == $past(pwdata[7:0]))
        else $error("IRQ pass register write did not take effect");

    a_write_refused : assert property (@(posedge pclk) disable iff (!presetn)
        (psel && penable && pready && pwrite && (!pstrb[0] || !mapped))
        |=> $stable(io_range_gates_low_reg) && $stable(io_range_gates_high_reg)
            && $stable(legacy_irq_pass_gates_reg))
        else $error("refused write changed a gate register");

    // Per-block gates
    assign port80_gate    = io_range_gates_low_reg[0];
    assign range_100_gate = io_range_gates_low_reg[1];
    assign range_200_gate = io_range_gates_low_reg[2];
    assign range_2e8_gate = io_range_gates_low_reg[3];
    assign range_2f0_gate = io_range_gates_low_reg[4];
    assign range_2f8_gate = io_range_gates_low_reg[5];
    assign range_300_gate = io_range_gates_low_reg[6];
    assign range_378_gate = io_range_gates_low_reg[7];
    assign range_3e8_gate = io_range_gates_high_reg[0];
    assign range_3f0_gate = io_range_gates_high_reg[1];
    assign range_3f8_gate = io_range_gates_high_reg[2];
    assign range_400_gate = io_range_gates_high_reg[3];

    // Upper nibble of the high register stays out
    assign gate_vec = {range_400_gate, range_3f8_gate, range_3f0_gate, range_3e8_gate,
                       range_378_gate, range_300_gate, range_2f8_gate, range_2f0_gate,
                       range_2e8_gate, range_200_gate, range_100_gate, port80_gate};

    // Range compare per block, both directions
    genvar gi;
    generate
        for (gi = 0; gi < lid_pkg::NUM_BLOCKS; gi++)
        begin : g_blk
            assign lpc_in_blk[gi]   = (lpc_cyc.port >= lid_pkg::BLK_LO[gi]) &&
                                      (lpc_cyc.port <= lid_pkg::BLK_HI[gi]);
            assign pc104_in_blk[gi] = (pc104_cyc.port >= lid_pkg::BLK_LO[gi]) &&
                                      (pc104_cyc.port <= lid_pkg::BLK_HI[gi]);

            a_block_open : assert property (@(posedge pclk) disable iff (!presetn)
                (lpc_cyc.valid && lpc_cyc.port == lid_pkg::BLK_HI[gi] && gate_vec[gi])
                |=> to_pc104_claim)
                else $error("enabled block port not claimed toward expansion bus");

            a_block_shut : assert property (@(posedge pclk) disable iff (!presetn)
                (pc104_cyc.valid && pc104_cyc.port == lid_pkg::BLK_LO[gi] && !gate_vec[gi])
                |=> !to_lpc_claim)
                else $error("disabled block port claimed toward LPC side");

            a_lpc_shut : assert property (@(posedge pclk) disable iff (!presetn)
                (lpc_cyc.valid && lpc_cyc.port == lid_pkg::BLK_LO[gi] && !gate_vec[gi])
                |=> !to_pc104_claim)
                else $error("disabled block port claimed toward expansion bus");

            a_pc104_open : assert property (@(posedge pclk) disable iff (!presetn)
                (pc104_cyc.valid && pc104_cyc.port == lid_pkg::BLK_HI[gi] && gate_vec[gi])
                |=> to_lpc_claim)
                else $error("enabled block port not claimed toward LPC side");
        end
    endgenerate

    assign lpc_hit   = lpc_cyc.valid & (|(lpc_in_blk & gate_vec));
    assign pc104_hit = pc104_cyc.valid & (|(pc104_in_blk & gate_vec));

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            to_pc104_claim_reg <= 1'b0;
            to_lpc_claim_reg   <= 1'b0;
        end
        else
        begin
            to_pc104_claim_reg <= lpc_hit;
            to_lpc_claim_reg   <= pc104_hit;
        end
    end

    // IRQ pass bits, bit i carries line IRQ_LINE[i]
    assign line3_pass  = legacy_irq_pass_gates_reg[0];
    assign line4_pass  = legacy_irq_pass_gates_reg[1];
    assign line5_pass  = legacy_irq_pass_gates_reg[2];
    assign line6_pass  = legacy_irq_pass_gates_reg[3];
    assign line7_pass  = legacy_irq_pass_gates_reg[4];
    assign line9_pass  = legacy_irq_pass_gates_reg[5];
    assign line10_pass = legacy_irq_pass_gates_reg[6];
    assign line11_pass = legacy_irq_pass_gates_reg[7];

    assign pass_vec = {line11_pass, line10_pass, line9_pass, line7_pass,
                       line6_pass, line5_pass, line4_pass, line3_pass};
    assign serirq_req_next = pc104_irq & pass_vec;

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            serirq_req_reg <= '0;
        else
            serirq_req_reg <= serirq_req_next;
    end

    generate
        for (gi = 0; gi < lid_pkg::NUM_IRQ; gi++)
        begin : g_irq
            a_irq_pass : assert property (@(posedge pclk) disable iff (!presetn)
                (pc104_irq[gi] && legacy_irq_pass_gates_reg[gi]) |=> serirq_req[gi])
                else $error("passed legacy IRQ not forwarded");

            a_irq_block : assert property (@(posedge pclk) disable iff (!presetn)
                (!legacy_irq_pass_gates_reg[gi]) |=> !serirq_req[gi])
                else $error("blocked legacy IRQ forwarded");

            a_irq_quiet : assert property (@(posedge pclk) disable iff (!presetn)
                (!pc104_irq[gi]) |=> !serirq_req[gi])
                else $error("legacy IRQ forwarded with no request");
        end
    endgenerate

    // Outputs
    assign prdata         = prdata_reg;
    assign pready         = pready_reg;
    assign pslverr        = pslverr_reg;
    assign to_pc104_claim = to_pc104_claim_reg;
    assign to_lpc_claim   = to_lpc_claim_reg;
    assign serirq_req     = serirq_req_reg;

    // Checks
    a_port80_reset : assert property (@(posedge pclk) disable iff (!presetn)
        $rose(presetn) |-> io_range_gates_low_reg == lid_pkg::RST_GATES_LOW)
        else $error("port 0x080 gate not enabled out of reset");

    a_port80_open : assert property (@(posedge pclk) disable iff (!presetn)
        (lpc_cyc.valid && lpc_cyc.port == lid_pkg::BLK_LO[0] && io_range_gates_low_reg[0]) |=> to_pc104_claim)
        else $error("port 0x080 not forwarded while enabled");

    a_high_nibble : assert property (@(posedge pclk) disable iff (!presetn)
        (lpc_cyc.valid && io_range_gates_low_reg == 8'h00 && io_range_gates_high_reg[3:0] == 4'h0)
        |=> !to_pc104_claim)
        else $error("claim with every block gate clear");

    a_pc104_clear : assert property (@(posedge pclk) disable iff (!presetn)
        (pc104_cyc.valid && io_range_gates_low_reg == 8'h00 && io_range_gates_high_reg[3:0] == 4'h0)
        |=> !to_lpc_claim)
        else $error("expansion claim with every block gate clear");

    a_no_claim : assert property (@(posedge pclk) disable iff (!presetn)
        (!lpc_cyc.valid || lpc_cyc.port > lid_pkg::BLK_HI[lid_pkg::NUM_BLOCKS-1]) |=> !to_pc104_claim)
        else $error("cycle outside all blocks claimed");

    a_pc104_outside : assert property (@(posedge pclk) disable iff (!presetn)
        (!pc104_cyc.valid || pc104_cyc.port > lid_pkg::BLK_HI[lid_pkg::NUM_BLOCKS-1]) |=> !to_lpc_claim)
        else $error("expansion cycle outside all blocks claimed");

    a_write_effect : assert property (@(posedge pclk) disable iff (!presetn)
        (psel && penable && pready && pwrite && pstrb[0] && paddr == lid_pkg::ADDR_GATES_HIGH)
        |=> io_range_gates_high_reg == $past(pwdata[7:0]))
        else $error("gate register write did not take effect");

    a_read_back : assert property (@(posedge pclk) disable iff (!presetn)
        (psel && penable && !pready && !pwrite && paddr == lid_pkg::ADDR_IRQ_GATES)
        |=> pready && prdata == {24'h000000, legacy_irq_pass_gates_reg})
        else $error("IRQ pass register read back wrong");

    a_low_read : assert property (@(posedge pclk) disable iff (!presetn)
        (psel && penable && !pready && !pwrite && paddr == lid_pkg::ADDR_GATES_LOW)
        |=> pready && prdata == {24'h000000, io_range_gates_low_reg})
        else $error("low gate register read back wrong");

    a_high_read : assert property (@(posedge pclk) disable iff (!presetn)
        (psel && penable && !pready && !pwrite && paddr == lid_pkg::ADDR_GATES_HIGH)
        |=> pready && prdata == {24'h000000, io_range_gates_high_reg})
        else $error("high gate register read back wrong");

    a_pready_wait : assert property (@(posedge pclk) disable iff (!presetn)
        (psel && penable && !pready) |=> pready ##1 !pready)
        else $error("APB access not answered after one wait state");

    a_unmapped_err : assert property (@(posedge pclk) disable iff (!presetn)
        (psel && penable && !pready && !(sel_low || sel_high || sel_irq)) |=> pslverr && prdata == 32'h00000000)
        else $error("unmapped access not flagged");

    a_mapped_clean : assert property (@(posedge pclk) disable iff (!presetn)
        (psel && penable && !pready && mapped) |=> !pslverr)
        else $error("mapped access flagged as error");

endmodule

// >>> lid_card_model.sv
// Expansion-bus card model that offers I/O cycles and raises legacy interrupts
`timescale 1ns/10ps

module lid_card_model
(
    // Clock and reset
    input  wire logic                 pclk,
    input  wire logic                 presetn,
    // Commands from the bench
    input  wire lid_pkg::lid_io_cyc_t cmd,
    input  wire logic [7:0]           irq_cmd,
    // Expansion bus side
    output lid_pkg::lid_io_cyc_t      pc104_cyc,
    output logic [7:0]                pc104_irq
);
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            pc104_cyc <= '0;
            pc104_irq <= '0;
        end
        else
        begin
            pc104_cyc.valid <= cmd.valid;
            // Idle port lines wander so a stale port cannot pass
            pc104_cyc.port  <= cmd.valid ? cmd.port : ~pc104_cyc.port;
            pc104_irq       <= irq_cmd;
        end
    end
endmodule

// >>> lid_pkg.sv
// Constants and types for the legacy I/O and IRQ forwarding decode block
package lid_pkg;

    // APB geometry
    localparam int unsigned ADDR_W = 12;
    localparam int unsigned DATA_W = 32;
    localparam int unsigned REG_W  = 8;

    // Register indices, byte address is four times the index
    localparam logic [9:0] IDX_GATES_LOW  = 10'h1D4;
    localparam logic [9:0] IDX_GATES_HIGH = 10'h1D5;
    localparam logic [9:0] IDX_IRQ_GATES  = 10'h1DE;

    localparam logic [11:0] ADDR_GATES_LOW  = {IDX_GATES_LOW, 2'h0};
    localparam logic [11:0] ADDR_GATES_HIGH = {IDX_GATES_HIGH, 2'h0};
    localparam logic [11:0] ADDR_IRQ_GATES  = {IDX_IRQ_GATES, 2'h0};

    // Reset values
    localparam logic [7:0] RST_GATES_LOW  = 8'h01;
    localparam logic [7:0] RST_GATES_HIGH = 8'h00;
    localparam logic [7:0] RST_IRQ_GATES  = 8'h00;

    // Port blocks, entry i is gated by bit i of the combined gate vector
    localparam int unsigned NUM_BLOCKS = 12;
    localparam int unsigned NUM_IRQ    = 8;

    localparam logic [15:0] BLK_LO [NUM_BLOCKS] = '{
        16'h0080, 16'h0100, 16'h0200, 16'h02E8, 16'h02F0, 16'h02F8,
        16'h0300, 16'h0378, 16'h03E8, 16'h03F0, 16'h03F8, 16'h0400
    };
    localparam logic [15:0] BLK_HI [NUM_BLOCKS] = '{
        16'h0080, 16'h01CF, 16'h02E7, 16'h02EF, 16'h02F7, 16'h02FF,
        16'h0377, 16'h03E7, 16'h03EF, 16'h03F7, 16'h03FF, 16'h0AFF
    };

    // Legacy interrupt number carried by each pass bit
    localparam logic [3:0] IRQ_LINE [NUM_IRQ] = '{
        4'h3, 4'h4, 4'h5, 4'h6, 4'h7, 4'h9, 4'hA, 4'hB
    };

    // One I/O cycle offered for forwarding
    typedef struct packed {
        logic        valid;
        logic [15:0] port;
    } lid_io_cyc_t;

endpackage

// >>> test_lid_bridge_decode.sv
// Self-checking testbench for the legacy I/O and IRQ forwarding decode block
`timescale 1ns/10ps

module test_lid_bridge_decode;
    logic                       pclk;
    logic                       presetn;
    logic                       psel;
    logic                       penable;
    logic                       pwrite;
    logic [11:0]                paddr;
    logic [31:0]                pwdata;
    logic [3:0]                 pstrb;
    logic [31:0]                prdata;
    logic                       pready;
    logic                       pslverr;
    lid_pkg::lid_io_cyc_t       lpc_cyc;
    lid_pkg::lid_io_cyc_t       card_cmd;
    lid_pkg::lid_io_cyc_t       pc104_cyc;
    logic                       to_pc104_claim;
    logic                       to_lpc_claim;
    logic [7:0]                 irq_cmd;
    logic [7:0]                 pc104_irq;
    logic [7:0]                 serirq_req;
    int                         failures;
    int                         n_checks;
    logic [31:0]                rd;
    logic                       err;
    logic [7:0]                 gv [3];
    logic [15:0]                pt;
    logic [11:0]                adr [3] = '{lid_pkg::ADDR_GATES_LOW, lid_pkg::ADDR_GATES_HIGH, lid_pkg::ADDR_IRQ_GATES};

    lid_bridge_decode dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .lpc_cyc(lpc_cyc), .to_pc104_claim(to_pc104_claim), .pc104_cyc(pc104_cyc),
        .to_lpc_claim(to_lpc_claim), .pc104_irq(pc104_irq), .serirq_req(serirq_req));

    lid_card_model card (.pclk(pclk), .presetn(presetn), .cmd(card_cmd), .irq_cmd(irq_cmd),
        .pc104_cyc(pc104_cyc), .pc104_irq(pc104_irq));

    initial
    begin
        pclk = 1'b0;
        forever #2 pclk = ~pclk;
    end

    function automatic logic exp_claim(input logic [15:0] p, input logic [7:0] l, input logic [7:0] h);
        return (l[0] && p == 16'h0080) || (l[1] && p inside {[16'h0100:16'h01CF]})
            || (l[2] && p inside {[16'h0200:16'h02E7]}) || (l[3] && p inside {[16'h02E8:16'h02EF]})
            || (l[4] && p inside {[16'h02F0:16'h02F7]}) || (l[5] && p inside {[16'h02F8:16'h02FF]})
            || (l[6] && p inside {[16'h0300:16'h0377]}) || (l[7] && p inside {[16'h0378:16'h03E7]})
            || (h[0] && p inside {[16'h03E8:16'h03EF]}) || (h[1] && p inside {[16'h03F0:16'h03F7]})
            || (h[2] && p inside {[16'h03F8:16'h03FF]}) || (h[3] && p inside {[16'h0400:16'h0AFF]});
    endfunction

    task automatic complete_run();
        $display("checks %0d mismatches %0d", n_checks, failures);
        if (failures == 0 && n_checks > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask

    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp)
        begin
            failures++;
            $display("MISMATCH %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d, input logic [3:0] s);
        int n;
        @(posedge pclk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= wr;
        paddr   <= a;
        pwdata  <= d;
        pstrb   <= s;
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do
        begin
            @(posedge pclk);
            n++;
        end
        while (pready !== 1'b1 && n < 16);
        rd = prdata;
        err = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        if (pready !== 1'b1)
        begin
            check("apb_wait", 32'h0, 32'h1);
            complete_run();
        end
    endtask

    // Write a gate register with random upper bits, then read it back
    task automatic wr_reg(input int j, input logic [7:0] v);
        gv[j] = v;
        apb(1'b1, adr[j], ($urandom() & 32'hFFFF_FF00) | {24'h000000, v}, 4'hF);
        apb(1'b0, adr[j], $urandom(), 4'h0);
        check("gate_readback", rd, {24'h0, v});
        check("gate_err", {31'h0, err}, 32'h0);
    endtask

    task automatic offer(input logic [15:0] p, input logic v, input logic [7:0] irq);
        @(posedge pclk);
        lpc_cyc  <= '{valid: v, port: p};
        card_cmd <= '{valid: v, port: p};
        irq_cmd  <= irq;
        repeat (3) @(posedge pclk);
        @(negedge pclk);
        check("to_pc104_claim", {31'h0, to_pc104_claim}, {31'h0, v & exp_claim(p, gv[0], gv[1])});
        check("to_lpc_claim", {31'h0, to_lpc_claim}, {31'h0, v & exp_claim(p, gv[0], gv[1])});
        check("serirq_req", {24'h0, serirq_req}, {24'h0, irq & gv[2]});
    endtask

    initial
    begin
        failures = 0;
        n_checks = 0;
        presetn = 1'b0;
        {psel, penable, pwrite, paddr, pwdata, pstrb} = '0;
        lpc_cyc = '0;
        card_cmd = '0;
        irq_cmd = '0;
        gv = '{8'h01, 8'h00, 8'h00};
        void'($urandom(32'hB974ACB2));
        repeat (16) @(posedge pclk);
        presetn <= 1'b1;
        for (int j = 0; j < 3; j++)
        begin
            apb(1'b0, adr[j], 32'h0, 4'h0);
            check("reset_value", rd, {24'h0, gv[j]});
        end
        offer(16'h0080, 1'b1, 8'hFF);
        offer(16'h0081, 1'b1, 8'h00);
        apb(1'b1, 12'h004, 32'hFFFF_FFFF, 4'hF);
        check("unmapped_err", {31'h0, err}, 32'h1);
        apb(1'b0, lid_pkg::ADDR_GATES_LOW + 12'h001, 32'h0, 4'h0);
        check("unaligned_err", {31'h0, err}, 32'h1);
        check("unaligned_data", rd, 32'h0);
        apb(1'b1, lid_pkg::ADDR_GATES_LOW, 32'h0000_00FE, 4'hE);
        apb(1'b0, lid_pkg::ADDR_GATES_LOW, 32'h0, 4'h0);
        check("strobe_off_write", rd, 32'h01);
        $display("test reset_and_refusal done");
        wr_reg(1, 8'hF0);
        offer(16'h0400, 1'b1, 8'h00);
        offer(16'h03F8, 1'b1, 8'h00);
        $display("test reserved_bits done");
        for (int i = 0; i < 200; i++)
        begin
            // Pass gates are set freely; no other interrupt owner exists here
            for (int j = 0; j < 3; j++)
                wr_reg(j, 8'($urandom()));
            for (int k = 0; k < 4; k++)
            begin
                pt = lid_pkg::BLK_LO[$urandom() % 12];
                case ($urandom() % 5)
                    0: pt = pt - 16'h0001;
                    1: pt = lid_pkg::BLK_HI[$urandom() % 12];
                    2: pt = lid_pkg::BLK_HI[$urandom() % 12] + 16'h0001;
                    3: pt = 16'($urandom());
                    default: pt = pt;
                endcase
                offer(pt, ($urandom() % 8) != 0, 8'($urandom()));
            end
        end
        $display("test random_gating done");
        @(posedge pclk);
        presetn <= 1'b0;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        gv = '{8'h01, 8'h00, 8'h00};
        apb(1'b0, lid_pkg::ADDR_GATES_LOW, 32'h0, 4'h0);
        check("rereset_low", rd, 32'h01);
        offer(16'h0080, 1'b1, 8'hFF);
        $display("test second_reset done");
        complete_run();
    end
endmodule
